// File: inc/bgnd_defs.svh
// shared constants of the single-wire background debugger
// Operation
// - secured: only hardware commands run, and no access to non-volatile memory
// - word access at an odd address is done at the even address below
// - no bus cycle is stolen while an external bus wait is active
// - hardware command waits for a free cycle, at most 128 cycles
// - a byte is eight bit times, each opened by a falling edge, idle high
// - each bit time lasts 16 target clock cycles
// - special single-chip mode leaves reset with background already active
`ifndef BGND_DEFS_SVH
`define BGND_DEFS_SVH

// bit timing in target clock ticks
`define BGND_TICK_LAST   4'hf
`define BGND_SAMPLE_TICK 4'ha
`define BGND_DRIVE_END   4'hd
`define BGND_BIT_LAST    3'h7

// last cycle of the free-cycle wait (128 cycles, counted from 0)
`define BGND_STEAL_LAST  8'h7f

// command codes
`define BGND_CMD_HW_RD_B 8'he4
`define BGND_CMD_HW_RD_W 8'hec
`define BGND_CMD_HW_WR_B 8'hc4
`define BGND_CMD_HW_WR_W 8'hcc
`define BGND_CMD_FW_RD_W 8'h68
`define BGND_CMD_FW_WR_W 8'h48
`define BGND_CMD_GO      8'h08
`define BGND_CMD_STEP    8'h10
`define BGND_CMD_BGND    8'h90

// command byte fields
`define BGND_CMD_READ_BIT 5
`define BGND_CMD_WORD_BIT 3

// defaults
`define BGND_TGT_DIV_DEF  4
`define BGND_NVM_BASE_DEF 16'h4000

`endif

// File: inc/bgnd_pkg.sv
// types of the single-wire background debugger
package bgnd_pkg;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0,
      ST_ADDR_H = 4'h1,
      ST_ADDR_L = 4'h2,
      ST_DATA_H = 4'h3,
      ST_DATA_L = 4'h4,
      ST_STEAL  = 4'h5,
      ST_RDATA  = 4'h6,
      ST_TX_H   = 4'h7,
      ST_TX_L   = 4'h8
   } ctl_fsm_type;

   typedef struct packed {
      ctl_fsm_type fsm;
      logic [7:0]  cmd;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [7:0]  wait_cnt;
      logic        active;
      logic        req;
      logic        we;
      logic        word;
      logic        go;
      logic        step;
      logic        load;
      logic [7:0]  tbyte;
   } ctl_state_type;

   typedef struct packed {
      logic       prev_in;
      logic [7:0] div;
      logic [3:0] tick;
      logic [2:0] idx;
      logic       busy;
      logic       txmode;
      logic [7:0] shreg;
      logic       pin_out;
      logic       pin_oe;
      logic       rx_valid;
      logic       tx_done;
   } phy_state_type;

endpackage

// File: inc/bgnd_if.sv
// byte link between command control and serial bit engine
`timescale 1ns/1ps
interface bgnd_if;
   logic       rx_valid;
   logic [7:0] rx_byte;
   logic       tx_load;
   logic [7:0] tx_byte;
   logic       tx_done;
   logic       clk_sel;

   modport phy (input tx_load, tx_byte, clk_sel, output rx_valid, rx_byte, tx_done);
   modport ctl (output tx_load, tx_byte, clk_sel, input rx_valid, rx_byte, tx_done);
endinterface

// File: design/bgnd_serial_phy.sv
// serial bit engine of the single-wire debug pin
`timescale 1ns/1ps
`include "bgnd_defs.svh"
module bgnd_serial_phy #(
   parameter int TGT_DIV = `BGND_TGT_DIV_DEF
) (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_pin,
   output logic      o_pin_out,
   output logic      o_pin_oe,
   bgnd_if.phy       lnk
);

   localparam logic [7:0] DIV_LAST = 8'(TGT_DIV - 1);

   bgnd_pkg::phy_state_type r;
   bgnd_pkg::phy_state_type s;
   logic                    tgt_en;

   if (TGT_DIV < 1 || TGT_DIV > 256) begin : g_bad_div
      $error("TGT_DIV must lie in 1..256");
   end

   // target clock tick: bus clock or divided
   assign tgt_en = lnk.clk_sel || (r.div == DIV_LAST);

   // bit timing, sampling and drive
   always_comb begin
      s          = r;
      s.rx_valid = 1'b0;
      s.tx_done  = 1'b0;
      s.prev_in  = i_pin;
      s.div      = tgt_en ? 8'h00 : 8'(r.div + 8'h01);
      if (lnk.tx_load) begin
         s.shreg  = lnk.tx_byte;
         s.txmode = 1'b1;
         s.idx    = 3'h0;
      end else if (!r.busy) begin
         if (r.prev_in && !i_pin) begin
            s.busy = 1'b1;
            s.tick = 4'h1; // detection edge counts as the first tick
            if (r.txmode && !r.shreg[7]) begin
               s.pin_oe  = 1'b1;
               s.pin_out = 1'b0;
            end
         end
      end else if (tgt_en) begin
         s.tick = 4'(r.tick + 4'h1);
         if (r.tick == `BGND_DRIVE_END) begin
            s.pin_oe = 1'b0;
         end
         if (!r.txmode && r.tick == `BGND_SAMPLE_TICK) begin
            s.shreg = {r.shreg[6:0], i_pin};
         end
         // a sent bit ends once the drive is released, so the next byte is loaded in time
         if (r.tick == `BGND_TICK_LAST ||
             (r.txmode && r.tick == `BGND_DRIVE_END)) begin
            s.busy   = 1'b0;
            s.pin_oe = 1'b0;
            s.idx    = 3'(r.idx + 3'h1);
            if (r.txmode) begin
               s.shreg = {r.shreg[6:0], 1'b0};
            end
            if (r.idx == `BGND_BIT_LAST) begin
               s.tx_done  = r.txmode;
               s.rx_valid = !r.txmode;
               s.txmode   = 1'b0;
            end
         end
      end
      if (i_rst) begin
         s         = '0;
         s.prev_in = 1'b1;
      end
   end

   // state register
   always_ff @(posedge i_clk) begin
      r <= s;
   end

   assign o_pin_out    = r.pin_out;
   assign o_pin_oe     = r.pin_oe;
   assign lnk.rx_valid = r.rx_valid;
   assign lnk.rx_byte  = r.shreg;
   assign lnk.tx_done  = r.tx_done;

   property p_bit_end;
      @(posedge i_clk) disable iff (i_rst)
      (r.busy && tgt_en && r.tick == `BGND_TICK_LAST) |=> !r.busy && !r.pin_oe;
   endproperty
   a_bit_end: assert property (p_bit_end) else $error("bit time did not end at tick 15");

   property p_idle_released;
      @(posedge i_clk) disable iff (i_rst)
      !r.busy |-> !r.pin_oe;
   endproperty
   a_idle_released: assert property (p_idle_released) else $error("pin driven between bits");

   property p_byte_eight;
      @(posedge i_clk) disable iff (i_rst)
      (r.rx_valid || r.tx_done) |-> r.idx == 3'h0 && $past(r.idx) == `BGND_BIT_LAST;
   endproperty
   a_byte_eight: assert property (p_byte_eight) else $error("byte not eight bits");

   property p_bit_start;
      @(posedge i_clk) disable iff (i_rst)
      $rose(r.busy) |-> r.tick == 4'h1 && $past(r.prev_in) && !$past(i_pin);
   endproperty
   a_bit_start: assert property (p_bit_start) else $error("bit began without falling edge");

endmodule // bgnd_serial_phy

// File: design/bgnd_debugger.sv
// command control of the background debugger with bus cycle stealing
`timescale 1ns/1ps
`include "bgnd_defs.svh"
module bgnd_debugger #(
   parameter int          TGT_DIV  = `BGND_TGT_DIV_DEF,
   parameter logic [15:0] NVM_BASE = `BGND_NVM_BASE_DEF
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_pin,
   output logic             o_pin_out,
   output logic             o_pin_oe,
   input  wire logic        i_clk_sel,
   input  wire logic        i_special_mode,
   input  wire logic        i_secure,
   input  wire logic        i_bus_free,
   input  wire logic        i_ext_wait,
   input  wire logic [15:0] i_bus_rdata,
   output logic             o_bus_req,
   output logic             o_bus_we,
   output logic             o_bus_word,
   output logic [15:0]      o_bus_addr,
   output logic [15:0]      o_bus_wdata,
   output logic             o_active,
   output logic             o_go,
   output logic             o_step
);

   bgnd_pkg::ctl_state_type r;
   bgnd_pkg::ctl_state_type s;
   logic                    fw_ok;
   logic                    is_read;
   logic                    blocked;
   logic                    take;

   bgnd_if lnk ();

   bgnd_serial_phy #(
      .TGT_DIV (TGT_DIV)
   ) u_phy (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_pin     (i_pin),
      .o_pin_out (o_pin_out),
      .o_pin_oe  (o_pin_oe),
      .lnk       (lnk.phy)
   );

   // access qualifiers
   assign fw_ok   = r.active && !i_secure;
   assign is_read = r.cmd[`BGND_CMD_READ_BIT];
   assign blocked = i_secure && (r.addr >= NVM_BASE);
   assign take    = !i_ext_wait &&
                    (i_bus_free || r.wait_cnt == `BGND_STEAL_LAST);

   // command sequencing
   always_comb begin
      s      = r;
      s.req  = 1'b0;
      s.go   = 1'b0;
      s.step = 1'b0;
      s.load = 1'b0;
      case (r.fsm)
         bgnd_pkg::ST_IDLE: begin
            if (lnk.rx_valid) begin
               s.cmd = lnk.rx_byte;
               case (lnk.rx_byte)
                  `BGND_CMD_HW_RD_B, `BGND_CMD_HW_RD_W,
                  `BGND_CMD_HW_WR_B, `BGND_CMD_HW_WR_W: begin
                     s.fsm = bgnd_pkg::ST_ADDR_H;
                  end
                  `BGND_CMD_FW_RD_W, `BGND_CMD_FW_WR_W: begin
                     if (fw_ok) begin
                        s.fsm = bgnd_pkg::ST_ADDR_H;
                     end
                  end
                  `BGND_CMD_GO: begin
                     if (fw_ok) begin
                        s.go     = 1'b1;
                        s.active = 1'b0;
                     end
                  end
                  `BGND_CMD_STEP: begin
                     s.step = fw_ok;
                  end
                  `BGND_CMD_BGND: begin
                     if (!i_secure) begin
                        s.active = 1'b1;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         bgnd_pkg::ST_ADDR_H: begin
            if (lnk.rx_valid) begin
               s.addr[15:8] = lnk.rx_byte;
               s.fsm        = bgnd_pkg::ST_ADDR_L;
            end
         end
         bgnd_pkg::ST_ADDR_L: begin
            if (lnk.rx_valid) begin
               s.word     = r.cmd[`BGND_CMD_WORD_BIT];
               s.we       = !is_read;
               s.wait_cnt = 8'h00;
               s.addr     = {r.addr[15:8], lnk.rx_byte};
               if (r.cmd[`BGND_CMD_WORD_BIT]) begin
                  s.addr[0] = 1'b0;
               end
               if (is_read) begin
                  s.fsm = bgnd_pkg::ST_STEAL;
               end else if (r.cmd[`BGND_CMD_WORD_BIT]) begin
                  s.fsm = bgnd_pkg::ST_DATA_H;
               end else begin
                  s.fsm = bgnd_pkg::ST_DATA_L;
               end
            end
         end
         bgnd_pkg::ST_DATA_H: begin
            if (lnk.rx_valid) begin
               s.wdata[15:8] = lnk.rx_byte;
               s.fsm         = bgnd_pkg::ST_DATA_L;
            end
         end
         bgnd_pkg::ST_DATA_L: begin
            if (lnk.rx_valid) begin
               s.wdata[7:0] = lnk.rx_byte;
               s.fsm        = bgnd_pkg::ST_STEAL;
            end
         end
         bgnd_pkg::ST_STEAL: begin
            if (take) begin
               if (blocked) begin
                  s.rdata = 16'h0000;
                  s.tbyte = 8'h00;
                  s.load  = is_read;
                  s.fsm   = !is_read ? bgnd_pkg::ST_IDLE :
                            (r.word ? bgnd_pkg::ST_TX_H : bgnd_pkg::ST_TX_L);
               end else begin
                  s.req = 1'b1;
                  s.fsm = is_read ? bgnd_pkg::ST_RDATA : bgnd_pkg::ST_IDLE;
               end
            end else if (r.wait_cnt != `BGND_STEAL_LAST) begin
               s.wait_cnt = 8'(r.wait_cnt + 8'h01);
            end
         end
         bgnd_pkg::ST_RDATA: begin
            s.rdata = i_bus_rdata;
            s.load  = 1'b1;
            s.tbyte = r.word ? i_bus_rdata[15:8] : i_bus_rdata[7:0];
            s.fsm   = r.word ? bgnd_pkg::ST_TX_H : bgnd_pkg::ST_TX_L;
         end
         bgnd_pkg::ST_TX_H: begin
            if (lnk.tx_done) begin
               s.load  = 1'b1;
               s.tbyte = r.rdata[7:0];
               s.fsm   = bgnd_pkg::ST_TX_L;
            end
         end
         bgnd_pkg::ST_TX_L: begin
            if (lnk.tx_done) begin
               s.fsm = bgnd_pkg::ST_IDLE;
            end
         end
         default: begin
            s.fsm = bgnd_pkg::ST_IDLE;
         end
      endcase
      if (i_rst) begin
         s        = '0;
         s.active = i_special_mode;
      end
   end

   // state register
   always_ff @(posedge i_clk) begin
      r <= s;
   end

   assign lnk.tx_load = r.load;
   assign lnk.tx_byte = r.tbyte;
   assign lnk.clk_sel = i_clk_sel;
   assign o_bus_req   = r.req;
   assign o_bus_we    = r.we;
   assign o_bus_word  = r.word;
   assign o_bus_addr  = r.addr;
   assign o_bus_wdata = r.wdata;
   assign o_active    = r.active;
   assign o_go        = r.go;
   assign o_step      = r.step;

   sequence s_wait_last;
      r.fsm == bgnd_pkg::ST_STEAL && r.wait_cnt == `BGND_STEAL_LAST && !i_ext_wait;
   endsequence

   property p_steal_bound;
      @(posedge i_clk) disable iff (i_rst)
      s_wait_last ##0 !blocked |=> o_bus_req;
   endproperty
   a_steal_bound: assert property (p_steal_bound) else $error("no steal after 128 cycles");

   property p_wait_cap;
      @(posedge i_clk) disable iff (i_rst)
      r.fsm == bgnd_pkg::ST_STEAL |-> r.wait_cnt <= `BGND_STEAL_LAST;
   endproperty
   a_wait_cap: assert property (p_wait_cap) else $error("free-cycle wait overran");

   property p_no_steal_in_wait;
      @(posedge i_clk) disable iff (i_rst)
      o_bus_req |-> !$past(i_ext_wait) && $past(r.fsm) == bgnd_pkg::ST_STEAL;
   endproperty
   a_no_steal_in_wait: assert property (p_no_steal_in_wait) else $error("steal in ext wait");

   property p_even_word;
      @(posedge i_clk) disable iff (i_rst)
      o_bus_req && o_bus_word |-> !o_bus_addr[0];
   endproperty
   a_even_word: assert property (p_even_word) else $error("word access at odd address");

   property p_secure_nvm;
      @(posedge i_clk) disable iff (i_rst)
      o_bus_req |-> !($past(i_secure) && o_bus_addr >= NVM_BASE);
   endproperty
   a_secure_nvm: assert property (p_secure_nvm) else $error("secured nvm access");

   property p_secure_fw;
      @(posedge i_clk) disable iff (i_rst)
      $past(i_secure) && $past(r.fsm) == bgnd_pkg::ST_IDLE |-> !o_go && !o_step;
   endproperty
   a_secure_fw: assert property (p_secure_fw) else $error("firmware command while secured");

   property p_reset_active;
      @(posedge i_clk)
      i_rst |=> o_active == $past(i_special_mode) && !o_bus_req;
   endproperty
   a_reset_active: assert property (p_reset_active) else $error("wrong active after reset");

endmodule // bgnd_debugger

// File: tb/bgnd_host.sv
// behavioural debug host on the far side of the single-wire debug pin
`timescale 1ns/1ps
module bgnd_host #(
   parameter int TGT_DIV = 4
) (
   input  wire logic i_clk,
   input  wire logic i_clk_sel,
   input  wire logic i_pin,
   output logic      o_drive_low
);
   // host waits in bus cycles before the next phase
   localparam int HW_RD_WAIT = 150;
   localparam int HW_WR_WAIT = 150;
   localparam int FW_RD_WAIT = 48;
   localparam int FW_WR_WAIT = 36;
   localparam int RUN_WAIT   = 76;
   // no acknowledge path here: a wide fixed margin while bus waits are in use
   localparam int EXT_WAIT_MARGIN = 300;

   // line released at start, pull-up keeps it high
   initial o_drive_low = 1'b0;

   // target clock ticks in bus cycles
   function automatic int tick_len();
      return (i_clk_sel === 1'b1) ? 1 : TGT_DIV;
   endfunction

   // one bit: falling edge, short low for 1, long low for 0, then idle high
   task automatic send_bit(input logic b);
      int t;
      t = tick_len();
      o_drive_low <= 1'b1;
      repeat ((b ? 4 : 12) * t) @(posedge i_clk);
      o_drive_low <= 1'b0;
      repeat ((b ? 12 : 4) * t) @(posedge i_clk);
   endtask

   // byte sent msb first as eight bit times
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         send_bit(b[i]);
      end
   endtask

   // host opens each bit and samples the device drive mid-bit
   task automatic recv_bits(input int n, output logic [15:0] v);
      int t;
      t = tick_len();
      v = 16'h0000;
      for (int i = 0; i < n; i++) begin
         o_drive_low <= 1'b1;
         repeat (2 * t) @(posedge i_clk);
         o_drive_low <= 1'b0;
         repeat (6 * t) @(posedge i_clk);
         v = {v[14:0], i_pin};
         repeat (8 * t) @(posedge i_clk);
      end
   endtask

   // fixed host delay in bus cycles
   task automatic wait_bus(input int n);
      repeat (n) @(posedge i_clk);
   endtask
endmodule // bgnd_host

// File: tb/background_debug_command_timing_tb.sv
// self-checking bench of the background debugger command timing
`timescale 1ns/1ps
`include "bgnd_defs.svh"
module background_debug_command_timing_tb;
   localparam int DIV = 4;
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end

   logic        clk = 1'b0;
   logic        rst, clk_sel, special, secure, bus_free, ext_wait;
   logic [15:0] rdata;
   logic        pin_out, pin_oe, host_low, bus_req, bus_we, bus_word, active, go, step;
   logic [15:0] bus_addr, bus_wdata, cap_addr, cap_wdata;
   logic        cap_we, cap_word;
   wire         single_wire_debug_pin;
   int          n_mismatch = 0;
   int          checks_done = 0;
   int          n_req = 0;
   int          n_go = 0;
   int          n_step = 0;

   // 25 MHz bus clock
   always #20 clk = ~clk;
   // resolved wire with pull-up
   assign single_wire_debug_pin = ~(host_low | (pin_oe & ~pin_out));

   bgnd_debugger #(.TGT_DIV(DIV)) uut (
      .i_clk(clk), .i_rst(rst), .i_pin(single_wire_debug_pin), .o_pin_out(pin_out),
      .o_pin_oe(pin_oe), .i_clk_sel(clk_sel), .i_special_mode(special), .i_secure(secure),
      .i_bus_free(bus_free), .i_ext_wait(ext_wait), .i_bus_rdata(rdata), .o_bus_req(bus_req),
      .o_bus_we(bus_we), .o_bus_word(bus_word), .o_bus_addr(bus_addr),
      .o_bus_wdata(bus_wdata), .o_active(active), .o_go(go), .o_step(step));

   bgnd_host #(.TGT_DIV(DIV)) host (
      .i_clk(clk), .i_clk_sel(clk_sel), .i_pin(single_wire_debug_pin), .o_drive_low(host_low));

   // bus side monitor: counts stolen cycles and pulses
   always @(posedge clk) begin
      if (bus_req === 1'b1) begin
         n_req <= n_req + 1;
         cap_addr <= bus_addr;
         cap_wdata <= bus_wdata;
         cap_we <= bus_we;
         cap_word <= bus_word;
      end
      if (go === 1'b1) n_go <= n_go + 1;
      if (step === 1'b1) n_step <= n_step + 1;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // command, address, then 0..2 data bytes
   task automatic host_cmd(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d,
                           input int nd);
      host.send_byte(c);
      host.send_byte(a[15:8]);
      host.send_byte(a[7:0]);
      if (nd == 2) host.send_byte(d[15:8]);
      if (nd > 0) host.send_byte(d[7:0]);
   endtask

   task automatic sc_reset(input logic mode);
      special <= mode;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(active, mode)
      `CHK({pin_oe, bus_req}, 2'b00)
   endtask

   task automatic sc_word_write();
      int r0;
      r0 = n_req;
      host_cmd(`BGND_CMD_HW_WR_W, 16'h1235, 16'habcd, 2);
      host.wait_bus(host.HW_WR_WAIT);
      `CHK(n_req, r0 + 1)
      `CHK(cap_addr, 16'h1234)
      `CHK({cap_we, cap_word}, 2'b11)
      `CHK(cap_wdata, 16'habcd)
   endtask

   task automatic sc_word_read();
      logic [15:0] v;
      rdata <= 16'h5aa5;
      host_cmd(`BGND_CMD_HW_RD_W, 16'h2001, 16'h0000, 0);
      host.wait_bus(host.HW_RD_WAIT);
      host.recv_bits(16, v);
      `CHK(v, 16'h5aa5)
      `CHK(cap_addr, 16'h2000)
      `CHK({cap_we, cap_word}, 2'b01)
   endtask

   // divided target clock: bit time stretches to 16 * DIV cycles
   task automatic sc_byte_slow();
      logic [15:0] v;
      clk_sel <= 1'b0;
      rdata <= 16'h3c3c;
      @(posedge clk);
      host_cmd(`BGND_CMD_HW_WR_B, 16'h0011, 16'h0077, 1);
      host.wait_bus(host.HW_WR_WAIT);
      `CHK(cap_wdata[7:0], 8'h77)
      `CHK({cap_we, cap_word, cap_addr}, {2'b10, 16'h0011})
      host_cmd(`BGND_CMD_HW_RD_B, 16'h0011, 16'h0000, 0);
      host.wait_bus(host.HW_RD_WAIT);
      host.recv_bits(8, v);
      `CHK(v[7:0], 8'h3c)
      clk_sel <= 1'b1;
      @(posedge clk);
   endtask

   // no free cycle: steal is forced after the 128-cycle wait
   task automatic sc_steal_wait();
      int r0, cnt;
      r0 = n_req;
      bus_free <= 1'b0;
      host_cmd(`BGND_CMD_HW_WR_B, 16'h0100, 16'h0001, 1);
      for (cnt = 0; cnt < 300 && n_req == r0; cnt++) @(posedge clk);
      `CHK(cnt >= 120 && cnt <= 140, 1'b1)
      bus_free <= 1'b1;
   endtask

   task automatic sc_ext_wait();
      int r0;
      r0 = n_req;
      ext_wait <= 1'b1;
      host_cmd(`BGND_CMD_HW_WR_B, 16'h0102, 16'h0055, 1);
      host.wait_bus(host.EXT_WAIT_MARGIN);
      `CHK(n_req, r0)
      ext_wait <= 1'b0;
      host.wait_bus(4);
      `CHK(n_req, r0 + 1)
   endtask

   task automatic sc_secure();
      logic [15:0] v;
      int r0;
      r0 = n_req;
      secure <= 1'b1;
      rdata <= 16'hffff;
      host_cmd(`BGND_CMD_HW_WR_W, 16'h4000, 16'h1111, 2);
      host.wait_bus(host.HW_WR_WAIT);
      `CHK(n_req, r0)
      host_cmd(`BGND_CMD_HW_RD_W, 16'h8000, 16'h0000, 0);
      host.wait_bus(host.HW_RD_WAIT);
      host.recv_bits(16, v);
      `CHK(v, 16'h0000)
      secure <= 1'b0;
   endtask

   task automatic sc_run_ctl();
      int g0, s0;
      g0 = n_go;
      s0 = n_step;
      host.send_byte(`BGND_CMD_STEP);
      host.wait_bus(host.RUN_WAIT);
      `CHK({n_step == s0 + 1, active}, 2'b11)
      host.send_byte(`BGND_CMD_GO);
      host.wait_bus(host.RUN_WAIT);
      `CHK({n_go == g0 + 1, active}, 2'b10)
      host.send_byte(`BGND_CMD_BGND);
      host.wait_bus(host.RUN_WAIT);
      `CHK(active, 1'b1)
   endtask

   // firmware word write and read while active, then step refused while secured
   task automatic sc_firmware();
      logic [15:0] v;
      int          r0, s0;
      r0 = n_req;
      s0 = n_step;
      rdata <= 16'h0ff0;
      host_cmd(`BGND_CMD_FW_WR_W, 16'h0200, 16'hbeef, 2);
      host.wait_bus(host.FW_WR_WAIT);
      `CHK(n_req, r0 + 1)
      `CHK({cap_we, cap_word, cap_addr, cap_wdata}, {2'b11, 16'h0200, 16'hbeef})
      host_cmd(`BGND_CMD_FW_RD_W, 16'h0202, 16'h0000, 0);
      host.wait_bus(host.FW_RD_WAIT);
      host.recv_bits(16, v);
      `CHK(v, 16'h0ff0)
      secure <= 1'b1;
      host.send_byte(`BGND_CMD_STEP);
      host.wait_bus(host.RUN_WAIT);
      `CHK({n_step, active}, {s0, 1'b1})
      secure <= 1'b0;
   endtask

   // watchdog well above the expected run length
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      end_sim();
   end

   initial begin
      rst = 1'b1;
      clk_sel = 1'b1;
      special = 1'b0;
      secure = 1'b0;
      bus_free = 1'b1;
      ext_wait = 1'b0;
      rdata = 16'h0000;
      sc_reset(1'b0);
      sc_word_write();
      sc_word_read();
      sc_byte_slow();
      sc_steal_wait();
      sc_ext_wait();
      sc_secure();
      sc_reset(1'b1);
      sc_run_ctl();
      sc_firmware();
      end_sim();
   end
endmodule // background_debug_command_timing_tb
